/* core/turnaround_pkg.sv */
package turnaround_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map: printed offsets are indices, byte address is 4x
	localparam int ADDR_WIDTH = 8;
	localparam logic [5:0] TURNAROUND_INDEX = 6'h1A;
	localparam logic [5:0] STATUS_INDEX = 6'h1B;
	localparam logic [7:0] TURNAROUND_ADDR = {TURNAROUND_INDEX, 2'b00};
	localparam logic [7:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};

	////////////////////////////////////////////////////////////////////////
	// Field layout of the turn-around register
	localparam int WAIT_LSB = 0;
	localparam int WAIT_WIDTH = 20;
	localparam int ACK_LSB = 24;
	localparam int ACK_WIDTH = 8;
	localparam logic [31:0] WRITABLE_MASK = 32'hFF0FFFFF;
	localparam logic [31:0] TURNAROUND_RESET = 32'h00000000;

	// Status register bit positions
	localparam int STATUS_WAIT_BUSY = 0;
	localparam int STATUS_ACK_BUSY = 1;

	////////////////////////////////////////////////////////////////////////
	// Timing: one response-wait tick is this many system clocks
	localparam int TICK_CYCLES = 128;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* core/tick_divider.sv */
`timescale 1ns/100ps
module tick_divider #(
	parameter int DIVIDE = turnaround_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Restart the tick phase
	input wire logic clear,
	// One-cycle enable every DIVIDE clocks
	output logic tick
);

	localparam int CW = $clog2(DIVIDE);
	localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

	typedef struct packed {
		logic [CW-1:0] count;
		logic tick;
	} state_type;

	state_type state_reg;
	state_type state_next;

	////////////////////////////////////////////////////////////////////////
	// Clearing aligns the first tick to the start of a delay, so a delay
	// of N never comes up short by a partial tick
	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (clear) begin
			state_next.count = '0;
		end else if (state_reg.count == LAST) begin
			state_next.count = '0;
			state_next.tick = 1'b1;
		end else begin
			state_next.count = state_reg.count + CW'(1);
		end
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tick = state_reg.tick;

endmodule

/* core/delay_counter.sv */
`timescale 1ns/100ps
module delay_counter #(
	parameter int WIDTH = turnaround_pkg::WAIT_WIDTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Control
	input wire logic start,
	input wire logic [WIDTH-1:0] load,
	input wire logic tick,
	// Status
	output logic busy,
	output logic done
);

	typedef struct packed {
		logic busy;
		logic done;
		logic [WIDTH-1:0] remaining;
	} state_type;

	state_type state_reg;
	state_type state_next;

	////////////////////////////////////////////////////////////////////////
	// A new start reloads even while busy; the latest event wins
	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		if (start) begin
			state_next.busy = 1'b1;
			state_next.remaining = load;
		end else if (state_reg.busy) begin
			if (state_reg.remaining == '0) begin
				state_next.busy = 1'b0;
				state_next.done = 1'b1;
			end else if (tick) begin
				state_next.remaining = state_reg.remaining - WIDTH'(1);
			end
		end
	end

	// State register
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign busy = state_reg.busy;
	assign done = state_reg.done;

endmodule

/* core/turnaround_timing.sv */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module turnaround_timing (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,

	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,

	// Transmitter side events
	input wire logic txDone,
	input wire logic wait_response_enable,
	// Receiver side events
	input wire logic frameGood,
	input wire logic filterPass,
	input wire logic ackRequest,
	input wire logic autoAckEnable,
	input wire logic symbolStrobe,

	// Turn-around results
	output logic receiverEnable,
	output logic ackTransmit,
	output logic responseWaitBusy,
	output logic ackWaitBusy
);

	////////////////////////////////////////////////////////////////////////
	// Block state

	// All bus and register state of the block in one word; the timers keep their own
	typedef struct packed {
		// Write address half, held until the write is performed
		logic awDone;
		logic [7:0] awAddr;
		// Write data half with its byte strobes
		logic wDone;
		logic [31:0] wData;
		logic [3:0] wStrb;
		// Write response, standing until bready
		logic bValid;
		logic [1:0] bResp;
		// Read response, standing until rready
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		// The turn-around register itself
		logic [31:0] cfgWord;
	} state_type;

	state_type state_reg;
	state_type state_next;

	logic [31:0] merged;
	logic [31:0] statusWord;
	logic [turnaround_pkg::WAIT_WIDTH-1:0] responseWaitDelay;
	logic [turnaround_pkg::ACK_WIDTH-1:0] ackTurnaroundDelay;
	logic waitStart;
	logic ackStart;
	logic waitTick;
	logic awTake;
	logic wTake;
	logic arTake;
	logic writePerform;
	logic bTake;
	logic rTake;
	logic writeStore;
	logic [1:0] writeResp;
	logic [31:0] readWord;
	logic [1:0] readResp;

	////////////////////////////////////////////////////////////////////////
	// Field views of the turn-around register

	// Delay fields pulled from their fixed positions; each view is a
	// plain slice, so a new write takes effect on the next start
	assign responseWaitDelay = state_reg.cfgWord[
		turnaround_pkg::WAIT_LSB +: turnaround_pkg::WAIT_WIDTH];
	assign ackTurnaroundDelay = state_reg.cfgWord[
		turnaround_pkg::ACK_LSB +: turnaround_pkg::ACK_WIDTH];

	// Status word shows the two timers' own state
	// Read-only; a write to it is answered and dropped
	always_comb begin
		statusWord = 32'h00000000;
		statusWord[turnaround_pkg::STATUS_WAIT_BUSY] = responseWaitBusy;
		statusWord[turnaround_pkg::STATUS_ACK_BUSY] = ackWaitBusy;
	end

	////////////////////////////////////////////////////////////////////////
	// Byte-lane merge of the held write data into the register

	// Unselected lanes keep their stored value
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : gLane
			assign merged[lane*8 +: 8] = state_reg.wStrb[lane] ?
				state_reg.wData[lane*8 +: 8] :
				state_reg.cfgWord[lane*8 +: 8];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Bus handshakes

	// Address and data are each held once taken; no new write is taken
	// until the response has gone, so only one write is ever in flight
	assign awready = !state_reg.awDone && !state_reg.bValid;
	assign wready = !state_reg.wDone && !state_reg.bValid;
	// The read side runs independently of the write side
	assign arready = !state_reg.rValid;
	assign awTake = awvalid && awready;
	assign wTake = wvalid && wready;
	assign arTake = arvalid && arready;
	// Both write halves held: the write happens at the next edge
	assign writePerform = state_reg.awDone && state_reg.wDone;
	// Responses leave at the edge where the master accepts them
	assign bTake = state_reg.bValid && bready;
	assign rTake = state_reg.rValid && rready;

	////////////////////////////////////////////////////////////////////////
	// Write decode: only the turn-around register stores; a write to the
	// read-only status word is answered but dropped
	always_comb begin
		writeStore = 1'b0;
		writeResp = turnaround_pkg::RESP_OKAY;
		unique case (state_reg.awAddr)
			turnaround_pkg::TURNAROUND_ADDR: begin
				writeStore = 1'b1;
			end
			turnaround_pkg::STATUS_ADDR: begin
				writeResp = turnaround_pkg::RESP_OKAY;
			end
			default: begin
				// Anything unmapped is refused
				writeResp = turnaround_pkg::RESP_SLVERR;
			end
		endcase
	end

	// Read decode; reserved bits are masked again on the way out so a
	// stray stored bit could never show
	always_comb begin
		readWord = 32'h00000000;
		readResp = turnaround_pkg::RESP_OKAY;
		unique case (araddr)
			turnaround_pkg::TURNAROUND_ADDR: begin
				readWord = state_reg.cfgWord &
					turnaround_pkg::WRITABLE_MASK;
			end
			turnaround_pkg::STATUS_ADDR: begin
				readWord = statusWord;
			end
			default: begin
				// Unmapped space reads zero
				readResp = turnaround_pkg::RESP_SLVERR;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for the bus slave and the register

	always_comb begin
		// Hold everything unless a handshake below moves it
		state_next = state_reg;

		// Capture write address and data in either order
		if (awTake) begin
			state_next.awDone = 1'b1;
			state_next.awAddr = awaddr;
		end

		// Data half may arrive before or after the address
		if (wTake) begin
			state_next.wDone = 1'b1;
			state_next.wData = wdata;
			state_next.wStrb = wstrb;
		end

		// Perform the write once both halves are held; the address and
		// data holders free up at the same edge the response rises
		if (writePerform) begin
			state_next.awDone = 1'b0;
			state_next.wDone = 1'b0;
			state_next.bValid = 1'b1;
			state_next.bResp = writeResp;
			if (writeStore) begin
				// Reserved bits can never be stored
				state_next.cfgWord = merged &
					turnaround_pkg::WRITABLE_MASK;
			end
		end else if (bTake) begin
			// Response taken by the master
			state_next.bValid = 1'b0;
		end

		// Read: one cycle from address to data, held until taken
		if (arTake) begin
			state_next.rValid = 1'b1;
			state_next.rData = readWord;
			state_next.rResp = readResp;
		end else if (rTake) begin
			state_next.rValid = 1'b0;
		end
	end

	// State register; both delay fields come up as zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.cfgWord <= turnaround_pkg::TURNAROUND_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Write response outputs straight from the state register
	assign bvalid = state_reg.bValid;
	assign bresp = state_reg.bResp;

	// Read response outputs, held until the master takes them
	assign rvalid = state_reg.rValid;
	assign rdata = state_reg.rData;
	assign rresp = state_reg.rResp;

	////////////////////////////////////////////////////////////////////////
	// Response-wait path: transmit done to receiver enable

	// Only a transmission that asked to wait arms the delay; without the
	// flag this block leaves the receiver to its normal control
	assign waitStart = txDone && wait_response_enable;

	// Microsecond tick, phase restarted by each armed transmission;
	// one tick is 128 system clocks
	tick_divider #(
		.DIVIDE(turnaround_pkg::TICK_CYCLES)
	) waitTicks (
		.clock(clock),
		.reset_n(reset_n),
		.clear(waitStart),
		.tick(waitTick)
	);

	// Receiver held off until the count runs out, then one enable pulse.
	// A zero delay still passes through the counter, so the receiver
	// comes on one clock after the armed edge, never in the same cycle
	delay_counter #(
		.WIDTH(turnaround_pkg::WAIT_WIDTH)
	) waitDelay (
		.clock(clock),
		.reset_n(reset_n),
		.start(waitStart),
		.load(responseWaitDelay),
		.tick(waitTick),
		.busy(responseWaitBusy),
		.done(receiverEnable)
	);

	////////////////////////////////////////////////////////////////////////
	// Acknowledgement path: good frame to acknowledgement start

	// Every acceptance condition must hold in the same cycle
	assign ackStart = frameGood && filterPass && ackRequest &&
		autoAckEnable;

	// Counts preamble symbol strobes, so PRF sets the real time; the
	// programmed floor per data rate is software's duty. A second good
	// frame while counting reloads the full delay, so the latest frame
	// is the one acknowledged
	delay_counter #(
		.WIDTH(turnaround_pkg::ACK_WIDTH)
	) ackDelay (
		.clock(clock),
		.reset_n(reset_n),
		.start(ackStart),
		.load(ackTurnaroundDelay),
		.tick(symbolStrobe),
		.busy(ackWaitBusy),
		.done(ackTransmit)
	);

endmodule

/* verif/turnaround_timing_sva.sv */
`timescale 1ns/100ps
module turnaround_timing_sva (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Radio events
	input wire logic txDone,
	input wire logic wait_response_enable,
	input wire logic frameGood,
	input wire logic filterPass,
	input wire logic ackRequest,
	input wire logic autoAckEnable,
	// Read data
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	// Results
	input wire logic receiverEnable,
	input wire logic ackTransmit,
	input wire logic responseWaitBusy,
	input wire logic ackWaitBusy
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////
	// Qualified starts of the two delays
	sequence waitStart;
		txDone && wait_response_enable;
	endsequence
	sequence ackStart;
		frameGood && filterPass && ackRequest && autoAckEnable;
	endsequence

	a_wait_starts: assert property (waitStart |=> responseWaitBusy)
		else $error("wait delay did not start");
	a_wait_ignored: assert property (txDone && !wait_response_enable
		&& !responseWaitBusy |=> !responseWaitBusy && !receiverEnable)
		else $error("wait delay started without enable");
	a_rx_ends_wait: assert property (receiverEnable |->
		$past(responseWaitBusy) && !responseWaitBusy)
		else $error("receiver enabled outside a wait");
	a_rx_single: assert property (receiverEnable |=> !receiverEnable)
		else $error("receiver enable longer than a pulse");
	a_ack_starts: assert property (ackStart |=> ackWaitBusy)
		else $error("ack delay did not start");
	a_ack_ignored: assert property (frameGood && !ackWaitBusy &&
		!(filterPass && ackRequest && autoAckEnable) |=> !ackWaitBusy)
		else $error("ack delay started for unqualified frame");
	a_ack_ends: assert property (ackTransmit |->
		$past(ackWaitBusy) && !ackWaitBusy)
		else $error("ack sent outside an ack delay");
	a_reserved_zero: assert property (rvalid && rresp == 2'h0 |->
		rdata[23:20] == 4'h0)
		else $error("reserved bits read nonzero");
endmodule

bind turnaround_timing turnaround_timing_sva u_sva (.clock, .reset_n,
	.txDone, .wait_response_enable, .frameGood, .filterPass, .ackRequest,
	.autoAckEnable, .rvalid, .rdata, .rresp, .receiverEnable, .ackTransmit,
	.responseWaitBusy, .ackWaitBusy);

/* verif/radio_model.sv */
`timescale 1ns/100ps
module radio_model #(
	parameter int SYM_PERIOD = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Radio events
	output logic txDone,
	output logic wait_response_enable,
	output logic frameGood,
	output logic filterPass,
	output logic ackRequest,
	output logic autoAckEnable,
	output logic symbolStrobe
);
	int symCount;

	// Idle values; qualifiers sit inverted between pulses to be unkind
	initial begin
		txDone = 1'h0;
		frameGood = 1'h0;
		{wait_response_enable, filterPass, ackRequest, autoAckEnable} = 4'hF;
	end

	// One-clock strobe per preamble symbol period
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			symCount <= 0;
			symbolStrobe <= 1'h0;
		end else begin
			symCount <= (symCount == SYM_PERIOD - 1) ? 0 : symCount + 1;
			symbolStrobe <= (symCount == SYM_PERIOD - 1);
		end
	end

	// Transmission complete, with or without waiting for a reply
	task automatic finish_tx(input logic w);
		@(posedge clock);
		txDone <= 1'h1;
		wait_response_enable <= w;
		@(posedge clock);
		txDone <= 1'h0;
		wait_response_enable <= ~w;
	endtask

	// Frame received; flags are {good, filtered, ack requested, auto-ack}
	task automatic deliver(input logic [3:0] f);
		@(posedge clock);
		{frameGood, filterPass, ackRequest, autoAckEnable} <= f;
		@(posedge clock);
		frameGood <= 1'h0;
		{filterPass, ackRequest, autoAckEnable} <= ~f[2:0];
	endtask
endmodule

/* verif/turnaround_timing_tb_top.sv */
`timescale 1ns/100ps
module turnaround_timing_tb_top;
	logic clock = 1'h0;
	logic reset_n = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd, cfg;
	logic [1:0] rsp;
	logic txDone, wait_response_enable, frameGood, filterPass;
	logic ackRequest, autoAckEnable, symbolStrobe;
	logic receiverEnable, ackTransmit, responseWaitBusy, ackWaitBusy;
	int badCount = 0, samplesChecked = 0, cycles = 0, n;

	always #4 clock = ~clock;

	turnaround_timing u_dut (.clock, .reset_n, .awvalid, .awready, .awaddr,
		.awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid,
		.bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
		.rready, .rdata, .rresp, .txDone, .wait_response_enable, .frameGood,
		.filterPass, .ackRequest, .autoAckEnable, .symbolStrobe,
		.receiverEnable, .ackTransmit, .responseWaitBusy, .ackWaitBusy);
	radio_model u_radio (.clock, .reset_n, .txDone, .wait_response_enable,
		.frameGood, .filterPass, .ackRequest, .autoAckEnable, .symbolStrobe);

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			badCount++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Handshakes are judged at the negedge, where the edge values are settled
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic ah, wh, bh;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge clock);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			rsp = bresp;
			@(posedge clock);
			if (ah) awvalid <= 1'h0;
			if (wh) wvalid <= 1'h0;
		end while (!bh);
		bready <= 1'h0;
		@(posedge clock); // Idle edge before the next call
	endtask

	task automatic axiRead(input logic [7:0] a);
		logic ah, rh;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge clock);
			ah = arvalid && arready;
			rh = rvalid;
			rd = rdata;
			rsp = rresp;
			@(posedge clock);
			if (ah) arvalid <= 1'h0;
		end while (!rh);
		rready <= 1'h0;
		@(posedge clock); // Idle edge before the next call
	endtask

	// Edges after the trigger edge until receiverEnable shows
	task automatic countRx();
		n = 0;
		do begin
			@(posedge clock);
			n++;
			@(negedge clock);
		end while (!receiverEnable && n < 400);
	endtask

	// Symbol strobes counted after the trigger edge until the ack starts;
	// a strobe in the cycle just before the ack lands after the count is
	// already out, so it is left out
	task automatic countAck();
		logic prev;
		n = 0;
		prev = 1'h0;
		@(negedge clock);
		for (int k = 0; k < 60 && !ackTransmit; k++) begin
			if (prev) n++;
			prev = symbolStrobe;
			@(negedge clock);
		end
		if (!ackTransmit) n = 99;
	endtask

	task print_verdict;
		$display("Mismatches %0d, comparisons %0d", badCount, samplesChecked);
		if (badCount == 0 && samplesChecked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Hang guard well above the expected run length
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			badCount++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clock);
		reset_n <= 1'h1;
		@(posedge clock);
		axiRead(turnaround_pkg::TURNAROUND_ADDR);
		check(rd, 32'h00000000);
		axiWrite(turnaround_pkg::TURNAROUND_ADDR, 32'hFFFFFFFF, 4'hF);
		axiRead(turnaround_pkg::TURNAROUND_ADDR);
		check(rd, 32'hFF0FFFFF);
		// Low two lanes cleared, ack field and upper wait bits kept
		axiWrite(turnaround_pkg::TURNAROUND_ADDR, 32'h00000000, 4'h3);
		axiRead(turnaround_pkg::TURNAROUND_ADDR);
		check(rd, 32'hFF0F0000);
		axiRead(8'h70);
		check(rsp, turnaround_pkg::RESP_SLVERR);
		check(rd, 32'h00000000);
		axiWrite(8'h70, 32'h00000001, 4'hF);
		check(rsp, turnaround_pkg::RESP_SLVERR);
		// Status is read-only: a write is answered and dropped
		axiWrite(turnaround_pkg::STATUS_ADDR, 32'hFFFFFFFF, 4'hF);
		check(rsp, turnaround_pkg::RESP_OKAY);
		// Zero and nonzero delays; 3 symbols meets the fastest-rate minimum
		// and stays clear of a far end that waits before listening
		for (int i = 0; i < 2; i++) begin
			cfg = i ? 32'h03000002 : 32'h00000000;
			axiWrite(turnaround_pkg::TURNAROUND_ADDR, cfg, 4'hF);
			u_radio.finish_tx(1'h1);
			countRx();
			check(n, i ? 128 * 2 + 2 : 1);
			u_radio.deliver(4'hF);
			countAck();
			check(n, cfg[31:24]);
		end
		// Without the enable the receiver stays off
		u_radio.finish_tx(1'h0);
		countRx();
		check(n, 400);
		// Any missing qualifier means no acknowledgement
		for (int i = 0; i < 4; i++) begin
			u_radio.deliver(4'hF ^ (4'h1 << i));
			countAck();
			check(n, 99);
		end
		// Both timers show busy in status, then both idle again
		u_radio.finish_tx(1'h1);
		u_radio.deliver(4'hF);
		axiRead(turnaround_pkg::STATUS_ADDR);
		check(rd, 32'h00000003);
		countRx();
		check(n < 400, 32'h00000001);
		axiRead(turnaround_pkg::STATUS_ADDR);
		check(rd, 32'h00000000);
		print_verdict();
	end
endmodule
